// [audio_ser_pkg.sv]
// Shared constants for the serial audio input link and its two ends.
// Assumes both ends run on one 50 MHz system clock.
package audio_ser_pkg;

  typedef enum logic [1:0] {FMT_I2S, FMT_RJ, FMT_LJ} fmt_t;
  typedef enum logic [1:0] {WW_16, WW_18, WW_20, WW_24} width_t;

  localparam int WORD_MAX = 24;
  localparam int SLOTS_PER_HALF = 32;
  localparam fmt_t FMT_RESET = FMT_I2S;
  localparam width_t WIDTH_RESET = WW_24;
  localparam int CLK_MHZ = 50;
  // Link clock half period: 80 ns at 50 MHz gives 4 cycles
  localparam int LINK_HALF_NS = 80;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS * CLK_MHZ) / 1000;
  localparam int I2S_DELAY = 1;
  localparam int LJ_DELAY = 0;

  function automatic logic [4:0] word_bits(input width_t w);
    case (w)
      WW_16: word_bits = 5'h10;
      WW_18: word_bits = 5'h12;
      WW_20: word_bits = 5'h14;
      default: word_bits = 5'h18;
    endcase
  endfunction

  // Clocks from frame sync edge to MSB, per format and width
  function automatic logic [5:0] msb_delay(input fmt_t f, input width_t w);
    case (f)
      FMT_RJ: msb_delay = 6'(SLOTS_PER_HALF) - {1'b0, word_bits(w)};
      FMT_LJ: msb_delay = 6'(LJ_DELAY);
      default: msb_delay = 6'(I2S_DELAY);
    endcase
  endfunction

  // Frame sync level that marks the left word
  function automatic logic left_level(input fmt_t f);
    left_level = (f != FMT_I2S);
  endfunction

endpackage

// [audio_ser_if.sv]
// Serial audio link: clock, frame sync and data from source to deframer.
// Assumes a testbench joins both ends through this interface.
`timescale 1ns/1ps
interface audio_ser_if;
  logic sclk;
  logic fsync;
  logic sdata;
  modport source (output sclk, output fsync, output sdata);
  modport sink (input sclk, input fsync, input sdata);
endinterface

// [audio_ser_source.sv]
// Serial audio source end: makes the link clock, frame sync and data.
// Assumes the user presents a word pair and holds it until taken.
`timescale 1ns/1ps
module audio_ser_source
  import audio_ser_pkg::*;
(
  // System
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // Configuration
  input wire fmt_t FMT_I,
  input wire width_t WIDTH_I,
  // Sample pair
  input wire logic [WORD_MAX-1:0] LEFT_I,
  input wire logic [WORD_MAX-1:0] RIGHT_I,
  output logic TAKE_O,
  // Link
  audio_ser_if.source LINK
);

  logic [2:0] div_reg;
  logic sclk_reg;
  logic fs_reg;
  logic sd_reg;
  logic [5:0] slot_reg;
  logic half_reg;
  logic [WORD_MAX-1:0] left_reg;
  logic [WORD_MAX-1:0] right_reg;
  logic fall;
  logic [5:0] next_slot;
  logic next_half;
  logic [5:0] rel;
  logic [WORD_MAX-1:0] word;
  logic [4:0] nbits;
  logic sd_word;

  assign LINK.sclk = sclk_reg;
  assign LINK.fsync = fs_reg;
  assign LINK.sdata = sd_reg;
  assign fall = sclk_reg && (div_reg == 3'(LINK_HALF_CYC - 1));

  ////////////////////////////////////////////////////////////////////
  // Clock divider
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      div_reg <= 3'h0;
      sclk_reg <= 1'b0;
    end
    else if (div_reg == 3'(LINK_HALF_CYC - 1))
    begin
      div_reg <= 3'h0;
      sclk_reg <= ~sclk_reg;
    end
    else
      div_reg <= div_reg + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////
  // Drive on falling edge so data is steady at rising edge
  always_comb
  begin
    next_slot = (slot_reg == 6'(SLOTS_PER_HALF - 1)) ? 6'h00 : slot_reg + 6'h01;
    next_half = (slot_reg == 6'(SLOTS_PER_HALF - 1)) ? ~half_reg : half_reg;
    nbits = word_bits(WIDTH_I);
    rel = next_slot - msb_delay(FMT_I, WIDTH_I);
    word = next_half ? right_reg : left_reg;
    sd_word = 1'b0;
    if (next_slot >= msb_delay(FMT_I, WIDTH_I) && rel < {1'b0, nbits})
      sd_word = word[5'(nbits - 5'h01 - rel[4:0])];
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      slot_reg <= 6'(SLOTS_PER_HALF - 1);
      half_reg <= 1'b1;
      fs_reg <= 1'b0;
      sd_reg <= 1'b0;
      left_reg <= '0;
      right_reg <= '0;
      TAKE_O <= 1'b0;
    end
    else
    begin
      TAKE_O <= 1'b0;
      if (fall)
      begin
        slot_reg <= next_slot;
        half_reg <= next_half;
        fs_reg <= next_half ^ left_level(FMT_I);
        sd_reg <= sd_word;
        if (next_half && next_slot == 6'(SLOTS_PER_HALF - 1))
        begin
          left_reg <= LEFT_I;
          right_reg <= RIGHT_I;
          TAKE_O <= 1'b1;
        end
      end
    end
  end

endmodule

// [audio_ser_deframer.sv]
// Function
// - Accept RJ, I2S, LJ; 16/18/20/24 bits
// - Sample data on rising serial clock
// - Right-justified: sync high means left
// - Right-justified MSB delay 16/14/12/8 clocks
// - Right-justified LSB ends before next sync edge
// - I2S default; sync low means left
// - I2S MSB one clock after sync
// - Left-justified: sync high means left
// - Left-justified MSB right at sync edge
//
// Deframer end: recovers left and right words from the serial link.
// Assumes link clock is far slower than CLOCK_I, one edge per 4 cycles.
`timescale 1ns/1ps
module audio_ser_deframer
  import audio_ser_pkg::*;
(
  // System
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // Configuration
  input wire fmt_t FMT_I,
  input wire width_t WIDTH_I,
  // Link
  audio_ser_if.sink LINK,
  // Word pair to encoder
  output logic [WORD_MAX-1:0] LEFT_O,
  output logic [WORD_MAX-1:0] RIGHT_O,
  output logic PAIR_VALID_O
);

  typedef enum logic [1:0] {S_WAIT, S_DELAY, S_SHIFT, S_DONE} state_t;

  state_t state_reg;
  logic [2:0] sclk_sync_reg;
  logic [1:0] fs_sync_reg;
  logic [1:0] sd_sync_reg;
  logic fs_prev_reg;
  logic is_left_reg;
  logic [5:0] cnt_reg;
  logic [4:0] bits_reg;
  logic [WORD_MAX-1:0] shift_reg;
  logic [WORD_MAX-1:0] left_hold_reg;
  logic rise;
  logic fs_edge;
  logic [5:0] delay;
  logic [4:0] nbits;
  logic [WORD_MAX-1:0] shifted;
  logic fs_now;
  logic sd_now;
  logic [WORD_MAX-1:0] first_word;
  logic msb_now;
  logic word_done;

  // True when the bit taken now completes the word
  function automatic logic last_bit(input logic [4:0] taken, input logic [4:0] total);
    last_bit = (5'(taken + 5'h01) == total);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Synchronisers; first stage feeds only the second
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      sclk_sync_reg <= 3'h0;
      fs_sync_reg <= 2'h0;
      sd_sync_reg <= 2'h0;
    end
    else
    begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], LINK.sclk};
      fs_sync_reg <= {fs_sync_reg[0], LINK.fsync};
      sd_sync_reg <= {sd_sync_reg[0], LINK.sdata};
    end
  end

  // Data and sync pass the same delay as the clock, so a rising edge
  // sees the values that were steady at it
  assign fs_now = fs_sync_reg[1];
  assign sd_now = sd_sync_reg[1];
  assign rise = sclk_sync_reg[1] && !sclk_sync_reg[2];
  assign fs_edge = fs_now != fs_prev_reg;
  assign delay = msb_delay(FMT_I, WIDTH_I);
  assign nbits = word_bits(WIDTH_I);
  assign first_word = {{(WORD_MAX-1){1'b0}}, sd_now};
  assign shifted = {shift_reg[WORD_MAX-2:0], sd_now};

  // MSB is taken at the sync edge itself when there is no delay
  assign msb_now = rise && (fs_edge ? (delay == 6'h00)
                                    : (state_reg == S_DELAY && cnt_reg == delay));
  assign word_done = rise && !fs_edge && state_reg == S_SHIFT && last_bit(bits_reg, nbits);

  ////////////////////////////////////////////////////////////////////
  // Sync level at each sync edge picks the channel
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      fs_prev_reg <= 1'b0;
      is_left_reg <= 1'b0;
    end
    else if (rise)
    begin
      fs_prev_reg <= fs_now;
      if (fs_edge)
        is_left_reg <= (fs_now == left_level(FMT_I));
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Frame walk, one step per rising link clock
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
      state_reg <= S_WAIT;
    else if (rise && fs_edge)
    begin
      if (delay != 6'h00)
        state_reg <= S_DELAY;
      else if (last_bit(5'h00, nbits))
        state_reg <= S_DONE;
      else
        state_reg <= S_SHIFT;
    end
    else if (rise)
    begin
      case (state_reg)
        S_DELAY:
        begin
          if (cnt_reg == delay)
            state_reg <= S_SHIFT;
        end
        S_SHIFT:
        begin
          if (last_bit(bits_reg, nbits))
            state_reg <= S_DONE;
        end
        S_DONE: state_reg <= S_DONE;
        S_WAIT: state_reg <= S_WAIT;
        default: state_reg <= S_WAIT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Slot count from the sync edge up to the MSB
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
      cnt_reg <= 6'h00;
    else if (rise && fs_edge)
      cnt_reg <= 6'h01;
    else if (rise && state_reg == S_DELAY)
      cnt_reg <= cnt_reg + 6'h01;
  end

  ////////////////////////////////////////////////////////////////////
  // Bits taken so far in the current word
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
      bits_reg <= 5'h00;
    else if (msb_now)
      bits_reg <= 5'h01;
    else if (rise && fs_edge)
      bits_reg <= 5'h00;
    else if (rise && state_reg == S_SHIFT)
      bits_reg <= bits_reg + 5'h01;
  end

  ////////////////////////////////////////////////////////////////////
  // Shifter; a cut word is dropped when a new edge restarts it
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
      shift_reg <= '0;
    else if (msb_now)
      shift_reg <= first_word;
    else if (rise && !fs_edge && state_reg == S_SHIFT)
      shift_reg <= shifted;
  end

  ////////////////////////////////////////////////////////////////////
  // Word hand-off: left is held until right completes the pair
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      left_hold_reg <= '0;
      LEFT_O <= '0;
      RIGHT_O <= '0;
      PAIR_VALID_O <= 1'b0;
    end
    else
    begin
      PAIR_VALID_O <= 1'b0;
      if (word_done && is_left_reg)
        left_hold_reg <= shifted;
      else if (word_done)
      begin
        LEFT_O <= left_hold_reg;
        RIGHT_O <= shifted;
        PAIR_VALID_O <= 1'b1;
      end
    end
  end

endmodule

// [audio_ser_sva.sv]
// Wire checks for the serial audio link between source and deframer.
// Assumes one system clock and a link clock of 4 high, 4 low cycles.
`timescale 1ns/1ps
module audio_ser_sva (
  // System
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // Link
  input wire logic sclk,
  input wire logic fsync,
  input wire logic sdata
);
  default clocking @(posedge CLOCK_I);
  endclocking
  default disable iff (RST_I);
  logic [8:0] half_cnt_reg;
  logic fs_prev_reg;
  logic seen_reg;
  ////////////////////////////////////////////////////////////////////////////////
  // Half frame length: 32 link clocks of 8 cycles
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      half_cnt_reg <= 9'h000;
      fs_prev_reg <= 1'b0;
      seen_reg <= 1'b0;
    end
    else
    begin
      fs_prev_reg <= fsync;
      half_cnt_reg <= (fsync != fs_prev_reg) ? 9'h001 : half_cnt_reg + 9'h001;
      if (fsync != fs_prev_reg)
        seen_reg <= 1'b1;
    end
  end
  sequence s_high4;
    sclk [*4] ##1 !sclk;
  endsequence
  sequence s_low4;
    !sclk [*4] ##1 sclk;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_sclk_high_width: assert property ($rose(sclk) |-> s_high4)
    else $error("link clock high phase wrong");
  a_sclk_low_width: assert property ($fell(sclk) |-> s_low4)
    else $error("link clock low phase wrong");
  a_sclk_period: assert property ($rose(sclk) |-> ##8 $rose(sclk))
    else $error("link clock period wrong");
  a_sync_on_low: assert property ($changed(fsync) |-> !sclk)
    else $error("frame sync moved while clock high");
  a_data_on_low: assert property ($changed(sdata) |-> !sclk)
    else $error("data moved while clock high");
  a_setup_at_rise: assert property ($rose(sclk) |-> $stable(fsync) && $stable(sdata))
    else $error("sync or data moved at rising clock");
  a_sync_to_rise: assert property ($changed(fsync) |-> ##[1:4] $rose(sclk))
    else $error("no rising clock after sync edge");
  a_half_length: assert property ($changed(fsync) && seen_reg |-> half_cnt_reg == 9'h100)
    else $error("half frame is not 32 link clocks");
endmodule

// [tb_top.sv]
// Testbench: source and deframer joined, every format and width.
// Assumes the package constants and a 50 MHz system clock.
`timescale 1ns/1ps
module tb_top import audio_ser_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  fmt_t fmt = FMT_I2S;
  width_t ww = WW_24;
  logic [23:0] li = 24'h800001;
  logic [23:0] ri = 24'h7ffffe;
  logic [23:0] lo, ro, wl, wr, sh, m;
  // Expected words by frame; a right-justified pair lands after the next take
  logic [23:0] xl [8];
  logic [23:0] xr [8];
  logic take, pv, sp, fp;
  logic [31:0] rnd = 32'h00000033;
  int err_total = 0;
  int samples_checked = 0;
  int takes, pairs, cyc, slot, d, w;
  // 12 configurations of about 2600 cycles each, with margin
  localparam int CYC_LIMIT = 60000;
  audio_ser_if lnk ();
  always #10 clk = ~clk;
  audio_ser_source audio_ser_source_i (.CLOCK_I(clk), .RST_I(rst), .FMT_I(fmt),
    .WIDTH_I(ww), .LEFT_I(li), .RIGHT_I(ri), .TAKE_O(take), .LINK(lnk));
  audio_ser_deframer audio_ser_deframer_i (.CLOCK_I(clk), .RST_I(rst), .FMT_I(fmt),
    .WIDTH_I(ww), .LINK(lnk), .LEFT_O(lo), .RIGHT_O(ro), .PAIR_VALID_O(pv));
  audio_ser_sva audio_ser_sva_i (.CLOCK_I(clk), .RST_I(rst), .sclk(lnk.sclk),
    .fsync(lnk.fsync), .sdata(lnk.sdata));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic int wid(input width_t x);
    return 16 + 2 * int'(x) + ((x == WW_24) ? 2 : 0);
  endfunction
  // Right-justified MSB lands so the LSB ends the half
  function automatic int dly(input fmt_t f, input int n);
    return (f == FMT_RJ) ? 32 - n : ((f == FMT_I2S) ? 1 : 0);
  endfunction
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    samples_checked++;
    if (e !== g)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic summarize;
    if (err_total == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Frame 0 carries reset-time data; pair n belongs to frame n-1
  always @(posedge clk)
  begin
    cyc++;
    sp <= lnk.sclk;
    if (rst)
    begin
      takes = 0;
      pairs = 0;
    end
    else
    begin
      if (pv)
      begin
        pairs++;
        if (pairs > 1)
        begin
          chk("left", xl[(pairs - 1) % 8], lo);
          chk("right", xr[(pairs - 1) % 8], ro);
          chk("wire_left", xl[(pairs - 1) % 8], wl);
          chk("wire_right", xr[(pairs - 1) % 8], wr);
        end
      end
      if (take)
      begin
        takes++;
        xl[takes % 8] = li & m;
        xr[takes % 8] = ri & m;
        rnd = lfsr(rnd);
        li <= rnd[23:0];
        rnd = lfsr(rnd);
        ri <= rnd[23:0];
      end
      if (lnk.sclk && !sp)
      begin
        slot = (lnk.fsync != fp) ? 0 : slot + 1;
        fp = lnk.fsync;
        if (slot >= d && slot < d + w)
          sh = {sh[22:0], lnk.sdata};
        if (slot == d + w - 1 && lnk.fsync == (fmt != FMT_I2S))
          wl = sh & m;
        else if (slot == d + w - 1)
          wr = sh & m;
      end
    end
  end
  initial
  begin
    for (int c = 0; c < 12; c++)
    begin
      rst <= 1'b1;
      fmt <= fmt_t'(c % 3);
      ww <= width_t'(c / 3);
      w = wid(width_t'(c / 3));
      d = dly(fmt_t'(c % 3), w);
      m = (24'h000001 << w) - 24'h000001;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      wait (pairs >= 5 || cyc >= CYC_LIMIT);
    end
    if (cyc >= CYC_LIMIT)
      err_total++;
    summarize();
  end
endmodule
